// file: include/tcwg_consts.svh
// constants for the timer compare and waveform block
// assumes a 32-bit apb slave with word-aligned registers
`ifndef TCWG_CONSTS_SVH
`define TCWG_CONSTS_SVH
`define TCWG_OFF_CTRLA 12'h000
`define TCWG_OFF_WAVE 12'h004
`define TCWG_OFF_CTRLE 12'h008
`define TCWG_OFF_CMDSET 12'h00C
`define TCWG_OFF_BVALID 12'h010
`define TCWG_OFF_FLAGS 12'h014
`define TCWG_OFF_COUNT 12'h018
`define TCWG_OFF_PER 12'h01C
`define TCWG_OFF_PERIOD_BUFFER 12'h020
`define TCWG_OFF_CMP0 12'h024
`define TCWG_OFF_CMPBUF0 12'h030
`define TCWG_OFF_PINOUT 12'h03C
`define TCWG_PER_RESET 16'hFFFF
`define TCWG_CMD_POS 2
`define TCWG_CMD_NONE 2'h0
`define TCWG_CMD_UPDATE 2'h1
`define TCWG_CMD_RESTART 2'h2
`define TCWG_CMD_RESET 2'h3
`define TCWG_WGM_NORMAL 2'h0
`define TCWG_WGM_FRQ 2'h1
`define TCWG_WGM_SS 2'h2
`define TCWG_WGM_DS 2'h3
`endif

// file: include/tcwg_pkg.sv
// types for the timer compare and waveform block
// assumes tcwg_consts.svh for numeric constants
package tcwg_pkg;
  typedef logic [15:0] tcwg_word_t;
  typedef enum logic [1:0] {
    TCWG_NORMAL = 2'b00,
    TCWG_FREQ = 2'b01,
    TCWG_SINGLE = 2'b10,
    TCWG_DUAL = 2'b11
  } tcwg_mode_e;
endpackage : tcwg_pkg

// file: core/tcwg_prescale.sv
// prescaler producing one-cycle timer tick enables
// assumes pclk is the peripheral clock
`timescale 1ns/1ps
module tcwg_prescale
  import tcwg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] prescale_select,
  output logic tick
);
  logic [9:0] div_q;
  logic [9:0] lim;

  always_comb begin
    unique case (prescale_select)
      3'h0: lim = 10'h000;
      3'h1: lim = 10'h001;
      3'h2: lim = 10'h003;
      3'h3: lim = 10'h007;
      3'h4: lim = 10'h00F;
      3'h5: lim = 10'h03F;
      3'h6: lim = 10'h0FF;
      3'h7: lim = 10'h3FF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 10'h000;
    end else if (!run || div_q >= lim) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

  assign tick = run && (div_q >= lim);
endmodule : tcwg_prescale

// file: core/tcwg_timer.sv
// compare channels, buffering and waveform outputs of a 16-bit timer
// assumes an apb master on pclk; one tick enable from the prescaler
`timescale 1ns/1ps
`include "tcwg_consts.svh"
module tcwg_timer
  import tcwg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] port_out,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2:0] pin_out
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic enable_q;
  logic [2:0] presc_q;
  tcwg_mode_e mode_q;
  logic [2:0] chan_en_q;
  logic dir_q;
  logic lock_q;
  logic buf_en_q;
  logic [3:0] bv_q;
  logic [3:0] flag_q;
  tcwg_word_t cnt_q;
  tcwg_word_t per_q;
  tcwg_word_t period_buffer_q;
  tcwg_word_t cmp_q [3];
  tcwg_word_t cmpbuf_q [3];
  logic [2:0] wo_q;
  logic [2:0] match_q;
  logic top_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [2:0] pin_q;

  logic tick;
  logic wr;
  logic rd;
  logic [1:0] cmd;
  logic do_restart;
  logic do_reset;
  logic at_top;
  logic at_bot;
  logic upd_cond;
  logic upd_now;
  logic [2:0] match;
  logic mapped;
  tcwg_word_t top_val;

  tcwg_prescale u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .run(enable_q),
    .prescale_select(presc_q),
    .tick(tick)
  );

  // access phase lasts two cycles; pready is registered and answers in the cycle after the first access cycle
  assign wr = psel && penable && pwrite && !pready_q;
  assign rd = psel && penable && !pwrite && !pready_q;
  assign cmd = (wr && paddr == `TCWG_OFF_CMDSET) ?
    pwdata[`TCWG_CMD_POS+1:`TCWG_CMD_POS] : `TCWG_CMD_NONE;
  assign do_restart = (cmd == `TCWG_CMD_RESTART);
  // reset only honoured while stopped
  assign do_reset = (cmd == `TCWG_CMD_RESET) && !enable_q;

  assign top_val = (mode_q == TCWG_FREQ) ? cmp_q[0] : per_q;
  assign at_top = (cnt_q == top_val);
  assign at_bot = (cnt_q == 16'h0000);

  // update point: top for up-counting, bottom for dual slope / down
  always_comb begin
    if (mode_q == TCWG_DUAL) begin
      upd_cond = tick && at_bot && dir_q;
    end else if (dir_q) begin
      upd_cond = tick && at_bot;
    end else begin
      upd_cond = tick && at_top;
    end
  end
  assign upd_now = (upd_cond && !lock_q) ||
    (cmd == `TCWG_CMD_UPDATE);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      presc_q <= 3'h0;
      mode_q <= TCWG_NORMAL;
      chan_en_q <= 3'h0;
      lock_q <= 1'b0;
      buf_en_q <= 1'b0;
    end else if (do_reset) begin
      enable_q <= 1'b0;
      presc_q <= 3'h0;
      mode_q <= TCWG_NORMAL;
      chan_en_q <= 3'h0;
      lock_q <= 1'b0;
      buf_en_q <= 1'b0;
    end else if (wr) begin
      if (paddr == `TCWG_OFF_CTRLA) begin
        enable_q <= pwdata[0];
        presc_q <= pwdata[3:1];
      end
      if (paddr == `TCWG_OFF_WAVE) begin
        mode_q <= tcwg_mode_e'(pwdata[1:0]);
        chan_en_q <= pwdata[6:4];
      end
      if (paddr == `TCWG_OFF_CTRLE) begin
        lock_q <= pwdata[1];
        buf_en_q <= pwdata[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // counter and direction
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      dir_q <= 1'b0;
    end else if (do_reset || do_restart) begin
      cnt_q <= 16'h0000;
      dir_q <= 1'b0;
    end else if (wr && paddr == `TCWG_OFF_COUNT) begin
      cnt_q <= pwdata[15:0];
    end else if (wr && paddr == `TCWG_OFF_CTRLE && mode_q != TCWG_DUAL) begin
      dir_q <= pwdata[0];
    end else if (tick) begin
      if (mode_q == TCWG_DUAL) begin
        // turn around at top and at bottom
        if (!dir_q && at_top) begin
          dir_q <= 1'b1;
          cnt_q <= cnt_q - 16'h0001;
        end else if (dir_q && at_bot) begin
          dir_q <= 1'b0;
          cnt_q <= cnt_q + 16'h0001;
        end else if (dir_q) begin
          cnt_q <= cnt_q - 16'h0001;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end else if (dir_q) begin
        cnt_q <= at_bot ? top_val : cnt_q - 16'h0001;
      end else if (at_top) begin
        cnt_q <= 16'h0000;
      end else begin
        // a count above a lowered top runs on to wrap at all ones
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // period, compare and buffers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q <= `TCWG_PER_RESET;
      period_buffer_q <= `TCWG_PER_RESET;
      bv_q[0] <= 1'b0;
    end else if (do_reset) begin
      per_q <= `TCWG_PER_RESET;
      period_buffer_q <= `TCWG_PER_RESET;
      bv_q[0] <= 1'b0;
    end else begin
      if (wr && paddr == `TCWG_OFF_PER) begin
        per_q <= pwdata[15:0];
      end else if (upd_now && bv_q[0]) begin
        per_q <= period_buffer_q;
      end
      if (wr && paddr == `TCWG_OFF_PERIOD_BUFFER) begin
        period_buffer_q <= pwdata[15:0];
        bv_q[0] <= buf_en_q;
      end else if (upd_now) begin
        bv_q[0] <= 1'b0;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      localparam logic [11:0] CMPA = `TCWG_OFF_CMP0 + 12'(4 * gi);
      localparam logic [11:0] BUFA = `TCWG_OFF_CMPBUF0 + 12'(4 * gi);

      assign match[gi] = (cnt_q == cmp_q[gi]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_q[gi] <= 16'h0000;
          cmpbuf_q[gi] <= 16'h0000;
          bv_q[gi+1] <= 1'b0;
        end else if (do_reset) begin
          cmp_q[gi] <= 16'h0000;
          cmpbuf_q[gi] <= 16'h0000;
          bv_q[gi+1] <= 1'b0;
        end else begin
          if (wr && paddr == CMPA) begin
            cmp_q[gi] <= pwdata[15:0];
          end else if (upd_now && bv_q[gi+1]) begin
            cmp_q[gi] <= cmpbuf_q[gi];
          end
          if (wr && paddr == BUFA) begin
            cmpbuf_q[gi] <= pwdata[15:0];
            bv_q[gi+1] <= buf_en_q;
          end else if (upd_now) begin
            bv_q[gi+1] <= 1'b0;
          end
        end
      end

      // waveform state, changes on the same tick as the trigger
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wo_q[gi] <= 1'b0;
          match_q[gi] <= 1'b0;
        end else if (do_reset || do_restart) begin
          wo_q[gi] <= 1'b0;
          match_q[gi] <= 1'b0;
        end else if (tick) begin
          match_q[gi] <= match[gi];
          unique case (mode_q)
            TCWG_FREQ: if (match[gi]) wo_q[gi] <= ~wo_q[gi];
            TCWG_SINGLE: begin
              // clear wins at bottom so cmp = 0 stays low
              if (match[gi]) wo_q[gi] <= 1'b0;
              else if (at_bot) wo_q[gi] <= 1'b1;
            end
            TCWG_DUAL: begin
              if (match[gi] && at_bot) wo_q[gi] <= 1'b0;
              else if (match[gi] && at_top) wo_q[gi] <= 1'b1;
              else if (match[gi]) wo_q[gi] <= dir_q;
              else if (at_bot) wo_q[gi] <= 1'b1;
            end
            TCWG_NORMAL: wo_q[gi] <= wo_q[gi];
          endcase
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // sticky flags: set wins over software clear (write one to clear)
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 4'h0;
      top_q <= 1'b0;
    end else if (do_reset) begin
      flag_q <= 4'h0;
      top_q <= 1'b0;
    end else begin
      top_q <= tick ? (dir_q ? at_bot : at_top) : top_q;
      for (int i = 0; i < 4; i++) begin
        if (i == 0 && tick && top_q) begin
          flag_q[0] <= 1'b1;
        end else if (i > 0 && tick && match_q[i-1]) begin
          flag_q[i] <= 1'b1;
        end else if (wr && paddr == `TCWG_OFF_FLAGS && pwdata[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pins and bus answer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        pin_q[i] <= (chan_en_q[i] && mode_q != TCWG_NORMAL) ?
          wo_q[i] : port_out[i];
      end
    end
  end

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `TCWG_OFF_CTRLA: prdata_q = {28'h0, presc_q, enable_q};
      `TCWG_OFF_WAVE: prdata_q = {25'h0, chan_en_q, 2'h0, mode_q};
      `TCWG_OFF_CTRLE: prdata_q = {29'h0, buf_en_q, lock_q, dir_q};
      `TCWG_OFF_CMDSET: prdata_q = 32'h0;
      `TCWG_OFF_BVALID: prdata_q = {28'h0, bv_q};
      `TCWG_OFF_FLAGS: prdata_q = {28'h0, flag_q};
      `TCWG_OFF_COUNT: prdata_q = {16'h0, cnt_q};
      `TCWG_OFF_PER: prdata_q = {16'h0, per_q};
      `TCWG_OFF_PERIOD_BUFFER: prdata_q = {16'h0, period_buffer_q};
      12'h024: prdata_q = {16'h0, cmp_q[0]};
      12'h028: prdata_q = {16'h0, cmp_q[1]};
      12'h02C: prdata_q = {16'h0, cmp_q[2]};
      12'h030: prdata_q = {16'h0, cmpbuf_q[0]};
      12'h034: prdata_q = {16'h0, cmpbuf_q[1]};
      12'h038: prdata_q = {16'h0, cmpbuf_q[2]};
      `TCWG_OFF_PINOUT: prdata_q = {29'h0, wo_q};
      default: begin
        prdata_q = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (rd) prdata <= prdata_q;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_out = pin_q;
endmodule : tcwg_timer

// file: tb/tcwg_port_model.sv
// port logic model driving the ordinary pin output values
// assumes it shares pclk and presetn with the timer
`timescale 1ns/1ps
module tcwg_port_model (
  input wire logic pclk,
  input wire logic presetn,
  output logic [2:0] port_out
);
  // every bit flips each cycle so a stale pin copy cannot match by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) port_out <= 3'h5;
    else port_out <= ~port_out;
  end
endmodule : tcwg_port_model

// file: tb/tcwg_timer_assertions.sv
// protocol and pin override checks for the timer block
// assumes it is bound onto tcwg_timer and sees only its ports
`timescale 1ns/1ps
`include "tcwg_consts.svh"
module tcwg_timer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] port_out,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] pin_out
);
  // ----------------
  // shadow of waveform setup
  // ----------------
  logic [6:0] wave_q;
  logic ena_q;
  logic [1:0] up_q;
  logic take;
  logic bad;
  logic [2:0] ovr;
  assign take = psel && penable && pwrite && !pready;
  assign bad = paddr > `TCWG_OFF_PINOUT || paddr[1:0] != 2'h0;
  assign ovr = wave_q[6:4] & {3{wave_q[1:0] != 2'h0}};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_q <= 7'h00;
      ena_q <= 1'b0;
    end else if (take) begin
      if (paddr == `TCWG_OFF_WAVE) wave_q <= pwdata[6:0];
      if (paddr == `TCWG_OFF_CTRLA) ena_q <= pwdata[0];
      if (paddr == `TCWG_OFF_CMDSET && pwdata[3:2] == 2'h3 && !ena_q)
        wave_q <= 7'h00;
    end
  end
  // pins copy stale reset values at first, so wait three edges out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_rd;
    s_acc ##0 !pwrite;
  endsequence
  ready_timing_a: assert property (s_acc |=> pready)
    else $error("pready missing after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  bad_addr_a: assert property (s_acc ##0 bad |=> pslverr)
    else $error("unmapped access not refused");
  good_addr_a: assert property (s_acc ##0 !bad |=> !pslverr)
    else $error("mapped access refused");
  bad_read_a: assert property (s_rd ##0 bad |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  cmd_zero_a: assert property (
    s_rd ##0 paddr == `TCWG_OFF_CMDSET |=> prdata == 32'h0)
    else $error("command field not read as zero");
  pin_override_a: assert property (up_q == 2'h3 |->
    ((pin_out ^ $past(port_out)) & ~(ovr | $past(ovr) | $past(ovr, 2)))
    == 3'h0)
    else $error("pin overridden while channel off");
endmodule : tcwg_timer_checker

bind tcwg_timer tcwg_timer_checker u_tcwg_timer_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .port_out(port_out),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out)
);

// file: tb/timer_compare_waveform_gen_tb_top.sv
// self-checking bench for the timer compare and waveform block
// assumes the timer, the port model and the bound checker
`timescale 1ns/1ps
`include "tcwg_consts.svh"
module timer_compare_waveform_gen_tb_top import tcwg_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [2:0] port_out, pin_out, prev;
  logic [31:0] seed = 32'hEBDA5DCC;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int hi[3], tg[3], cv[3];
  int c, p, k, n;
  always #50 pclk = ~pclk;
  tcwg_timer u_tcwg_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .port_out(port_out), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_out(pin_out));
  tcwg_port_model u_tcwg_port_model (.pclk(pclk), .presetn(presetn),
    .port_out(port_out));
  // ----------------
  // helpers
  // ----------------
  function automatic logic [31:0] f_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : f_lfsr
  task automatic rnd(input int lo, input int span, output int v);
    seed = f_lfsr(seed);
    v = lo + int'(seed[15:0]) % span;
  endtask : rnd
  function automatic int f_ss(input int per, input int cmp);
    return (cmp > per) ? per + 1 : cmp;
  endfunction : f_ss
  function automatic int f_ds(input int per, input int cmp);
    return (cmp >= per) ? 2 * per : 2 * cmp;
  endfunction : f_ds
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // holds the request until pready is sampled, then idles one edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    // a bus answer that never comes counts against the run
    if (pready !== 1'b1) begin
      err_count++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic setup(input logic [31:0] wv, input int per);
    apb(1'b1, `TCWG_OFF_WAVE, wv);
    apb(1'b1, `TCWG_OFF_PER, per);
    for (int i = 0; i < 3; i++) apb(1'b1, `TCWG_OFF_CMP0 + 4 * i, cv[i]);
    apb(1'b1, `TCWG_OFF_CMDSET, 32'h8);
  endtask : setup
  task automatic measure(input int w);
    hi = '{0, 0, 0};
    tg = '{0, 0, 0};
    prev = pin_out;
    repeat (w) begin
      @(posedge pclk);
      for (int i = 0; i < 3; i++) begin
        hi[i] += int'(pin_out[i]);
        tg[i] += int'(pin_out[i] !== prev[i]);
      end
      prev = pin_out;
    end
  endtask : measure
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------
  // scenarios
  // ----------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TCWG_OFF_PER, 0);
    chk("per reset", 32'hFFFF, rd);
    apb(1'b0, 12'h040, 0);
    chk("unmapped err", 1, er);
    $display("test reset done");
    apb(1'b1, `TCWG_OFF_CTRLE, 32'h6);
    rnd(1, 65534, p);
    rnd(1, 65534, k);
    apb(1'b1, `TCWG_OFF_PERIOD_BUFFER, p);
    apb(1'b1, `TCWG_OFF_CMPBUF0, k);
    apb(1'b0, `TCWG_OFF_PER, 0);
    chk("per held", 32'hFFFF, rd);
    apb(1'b0, `TCWG_OFF_CMP0, 0);
    chk("cmp held", 0, rd);
    apb(1'b0, `TCWG_OFF_BVALID, 0);
    chk("valid set", 32'h3, rd);
    apb(1'b1, `TCWG_OFF_CMDSET, 32'h4);
    apb(1'b0, `TCWG_OFF_PER, 0);
    chk("per update", p, rd);
    apb(1'b0, `TCWG_OFF_CMP0, 0);
    chk("cmp update", k, rd);
    apb(1'b0, `TCWG_OFF_BVALID, 0);
    chk("valid clear", 0, rd);
    apb(1'b1, `TCWG_OFF_CTRLE, 0);
    apb(1'b1, `TCWG_OFF_PER, k);
    apb(1'b0, `TCWG_OFF_PER, 0);
    chk("per direct", k, rd);
    $display("test buffering done");
    apb(1'b1, `TCWG_OFF_PER, 32'hFFFF);
    apb(1'b1, `TCWG_OFF_CTRLA, 32'h1);
    apb(1'b1, `TCWG_OFF_CMDSET, 32'h8);
    repeat (60) @(posedge pclk);
    apb(1'b1, `TCWG_OFF_PER, 32'hA);
    apb(1'b0, `TCWG_OFF_COUNT, 0);
    chk("wrap first", 1, 32'(rd[15:0] > 16'h000A));
    $display("test wrap done");
    for (n = 0; n < 3; n++) begin
      c = 0;
      if (n > 0) rnd(1, 7, c);
      rnd(0, c + 1, k);
      cv = '{c, k, 0};
      setup(32'h31, 32'hFFFF);
      repeat (8 * (c + 1)) @(posedge pclk);
      measure(4 * (c + 1));
      chk("freq ch0", 4, tg[0]);
      chk("freq ch1", 4, tg[1]);
    end
    cv = '{20, 0, 0};
    setup(32'h31, 32'hFFFF);
    for (n = 0; n < 100 && pin_out[0] !== 1'b1; n++) @(posedge pclk);
    apb(1'b1, `TCWG_OFF_CMDSET, 32'h8);
    chk("restart pin", 0, pin_out[0]);
    apb(1'b0, `TCWG_OFF_COUNT, 0);
    chk("restart count", 1, 32'(rd < 10));
    $display("test frequency done");
    rnd(2, 8, p);
    rnd(1, p, k);
    cv = '{0, p + 1, k};
    setup(32'h72, p);
    repeat (4 * (p + 1)) @(posedge pclk);
    measure(p + 1);
    for (int i = 0; i < 3; i++) chk("ss duty", f_ss(p, cv[i]), hi[i]);
    apb(1'b0, `TCWG_OFF_FLAGS, 0);
    chk("cmp flag", 1, rd[3]);
    rnd(3, 7, p);
    rnd(1, p - 1, k);
    cv = '{0, p, k};
    setup(32'h73, p);
    repeat (8 * p) @(posedge pclk);
    measure(2 * p);
    for (int i = 0; i < 3; i++) chk("ds duty", f_ds(p, cv[i]), hi[i]);
    $display("test pwm done");
    apb(1'b1, `TCWG_OFF_CMDSET, 32'hC);
    apb(1'b0, `TCWG_OFF_PER, 0);
    chk("reset refused", p, rd);
    apb(1'b1, `TCWG_OFF_CTRLA, 0);
    apb(1'b1, `TCWG_OFF_CMDSET, 32'hC);
    apb(1'b0, `TCWG_OFF_PER, 0);
    chk("reset per", 32'hFFFF, rd);
    apb(1'b0, `TCWG_OFF_WAVE, 0);
    chk("reset wave", 0, rd);
    $display("test command done");
    report_and_stop();
  end
endmodule : timer_compare_waveform_gen_tb_top
